// ==== hw/erase_timer.sv ====
// self-timed chip erase sequencer with failure capture
`timescale 1ns/1ps
module erase_timer
  import flash_guard_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = CHIP_ERASE_CYCLES
)(
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  srst_in,
  // control
  input  wire logic  start_in,
  input  wire logic  fail_in,
  // state
  output logic       busy_out,
  output logic       done_out,
  output logic       error_out
);
  import flash_guard_pkg::*;

  typedef struct packed {
    logic                   busy;
    logic [ERASE_CNT_W-1:0] cnt;
    logic                   done;
    logic                   err;
    logic                   fail_seen;
  } timer_s;

  timer_s st;
  timer_s next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (st.busy) begin
      next_st.fail_seen = st.fail_seen | fail_in;
      if (st.cnt == '0) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.err  = st.fail_seen | fail_in;
      end else begin
        next_st.cnt = st.cnt - ERASE_CNT_W'(1);
      end
    end else if (start_in) begin
      // error flag describes the latest cycle only
      next_st.busy      = 1'b1;
      next_st.cnt       = ERASE_CNT_W'(ERASE_CYCLES - 1);
      next_st.err       = 1'b0;
      next_st.fail_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy_out  = st.busy;
  assign done_out  = st.done;
  assign error_out = st.err;

endmodule

// ==== hw/flash_guard_pkg.sv ====
// constants, opcodes and status layout of the flash write guard
package flash_guard_pkg;

  // opcodes
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_CE_A    = 8'h60;
  localparam logic [7:0] OP_CE_B    = 8'h62;
  localparam logic [7:0] OP_CE_C    = 8'hc7;
  localparam logic [7:0] OP_RDSR    = 8'h05;
  localparam logic [7:0] OP_WRSR    = 8'h01;

  // status byte 1 bit positions
  localparam int unsigned SR_BUSY   = 0;
  localparam int unsigned SR_WEL    = 1;
  localparam int unsigned SR_BP0    = 2;
  localparam int unsigned SR_EPE    = 5;
  localparam int unsigned SR_BPL    = 7;
  // status byte 2 bit positions
  localparam int unsigned SR2_BUSY  = 0;
  localparam int unsigned SR2_EPE   = 5;

  // reset and shipped values
  localparam logic BP0_SHIPPED      = 1'b0;
  localparam logic BPL_POWER_UP     = 1'b0;

  // timing
  localparam int unsigned CLK_FREQ_HZ         = 40_000_000;
  localparam int unsigned CHIP_ERASE_TIME_MS  = 100;
  localparam int unsigned CHIP_ERASE_CYCLES   =
    CHIP_ERASE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned ERASE_CNT_W         = 32;

  // pin synchroniser lanes
  localparam int unsigned SYNC_W    = 4;
  localparam int unsigned IDX_SCK   = 0;
  localparam int unsigned IDX_CS    = 1;
  localparam int unsigned IDX_MOSI  = 2;
  localparam int unsigned IDX_WP    = 3;
  localparam logic [3:0] SYNC_RESET = 4'ha;

  typedef enum logic [2:0] {
    CMD_OTHER,
    CMD_WREN,
    CMD_WRDI,
    CMD_CHIP_ERASE,
    CMD_RDSR,
    CMD_WRSR
  } cmd_e;

  function automatic cmd_e decode_op(input logic [7:0] op);
    cmd_e c;
    c = CMD_OTHER;
    if (op == OP_WREN) c = CMD_WREN;
    if (op == OP_WRDI) c = CMD_WRDI;
    if (op == OP_CE_A || op == OP_CE_B || op == OP_CE_C) c = CMD_CHIP_ERASE;
    if (op == OP_RDSR) c = CMD_RDSR;
    if (op == OP_WRSR) c = CMD_WRSR;
    return c;
  endfunction

endpackage

// ==== hw/flash_write_guard.sv ====
// command-level write guard and chip erase of a serial flash
`timescale 1ns/1ps

module flash_write_guard
  import flash_guard_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = CHIP_ERASE_CYCLES
)(
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  srst_in,
  // serial bus pins
  input  wire logic  sck_in,
  input  wire logic  cs_n_in,
  input  wire logic  mosi_in,
  output logic       miso_out,
  output logic       miso_oe_out,
  // write-protect pin
  input  wire logic  wp_n_in,
  // nonvolatile store of the array protect bit
  input  wire logic  bp0_nv_in,
  output logic       bp0_nv_out,
  output logic       bp0_nv_we_out,
  // array interface
  input  wire logic  erase_fail_in,
  output logic       array_erase_out,
  // status
  output logic       write_latch_flag_out,
  output logic       busy_out,
  output logic       array_protect_bit_out,
  output logic       protect_lock_bit_out,
  output logic       erase_program_error_flag_out,
  output logic       hw_locked_out
);
  import flash_guard_pkg::*;

  typedef struct packed {
    logic       loaded;
    logic       write_latch_flag;
    logic       bp0;
    logic       protect_lock_bit;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] opcode;
    logic [7:0] shift;
    logic [7:0] wr_byte;
    logic       miso;
    logic       miso_oe;
    logic       sck_d;
    logic       cs_d;
    logic       nv_we;
  } guard_s;

  guard_s st;
  guard_s next_st;

  // chip select idles high; a zero here would fake a release after reset
  localparam guard_s GUARD_RESET = '{cs_d: 1'b1, default: '0};

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] lvl;
  logic              sck;
  logic              cs_n;
  logic              mosi;
  logic              wp_n;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic              aligned;
  logic              misaligned;
  logic              hw_locked;
  logic              erase_start;
  logic              erase_busy;
  logic              erase_done;
  logic              erase_err;
  cmd_e              cmd;
  logic [7:0]        rd_byte;

  assign pins = {wp_n_in, mosi_in, cs_n_in, sck_in};

  pin_sync3 u_sync (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .pins_in   (pins),
    .level_out (lvl)
  );

  erase_timer #(
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_timer (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .start_in  (erase_start),
    .fail_in   (erase_fail_in),
    .busy_out  (erase_busy),
    .done_out  (erase_done),
    .error_out (erase_err)
  );

  assign sck  = lvl[IDX_SCK];
  assign cs_n = lvl[IDX_CS];
  assign mosi = lvl[IDX_MOSI];
  assign wp_n = lvl[IDX_WP];

  assign sck_rise = sck & ~st.sck_d;
  assign sck_fall = ~sck & st.sck_d;
  assign cs_fall  = ~cs_n & st.cs_d;
  assign cs_rise  = cs_n & ~st.cs_d;

  // a command counts only with a whole opcode and a byte-aligned end, except that a misaligned chip erase still clears the latch
  assign aligned    = (st.bit_cnt == 3'h0) && (st.byte_cnt != 2'h0);
  assign misaligned = (st.bit_cnt != 3'h0) && (st.byte_cnt != 2'h0);
  assign cmd        = decode_op(st.opcode);
  assign hw_locked  = ~wp_n & st.protect_lock_bit;

  // erase only on release, whole opcode, latch set, array unprotected
  assign erase_start = cs_rise && aligned && !erase_busy &&
                       (cmd == CMD_CHIP_ERASE) && st.write_latch_flag &&
                       !st.bp0;

  // status bytes are built live so reads work mid-erase
  function automatic logic [7:0] status_byte(input logic second);
    logic [7:0] b;
    b = 8'h00;
    if (second) begin
      b[SR2_BUSY] = erase_busy;
      b[SR2_EPE]  = erase_err;
    end else begin
      b[SR_BUSY]  = erase_busy;
      b[SR_WEL]   = st.write_latch_flag;
      b[SR_BP0]   = st.bp0;
      b[SR_EPE]   = erase_err;
      b[SR_BPL]   = st.protect_lock_bit;
    end
    return b;
  endfunction

  always_comb begin
    next_st       = st;
    next_st.sck_d = sck;
    next_st.cs_d  = cs_n;
    next_st.nv_we = 1'b0;
    rd_byte       = status_byte(~st.byte_cnt[0]);

    // the stored protect bit is taken once, after reset is released
    if (!st.loaded) begin
      next_st.loaded = 1'b1;
      next_st.bp0    = bp0_nv_in;
    end

    if (cs_fall) begin
      next_st.bit_cnt  = 3'h0;
      next_st.byte_cnt = 2'h0;
      next_st.opcode   = 8'h00;
    end else if (!cs_n && sck_rise) begin
      next_st.shift   = {st.shift[6:0], mosi};
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == 3'h7) begin
        // byte count saturates; trailing bytes are ignored
        if (st.byte_cnt != 2'h3) begin
          next_st.byte_cnt = st.byte_cnt + 2'h1;
        end
        if (st.byte_cnt == 2'h0) begin
          next_st.opcode = {st.shift[6:0], mosi};
        end
        if (st.byte_cnt == 2'h1) begin
          next_st.wr_byte = {st.shift[6:0], mosi};
        end
      end
    end

    // mode 0: data out changes on the falling edge
    if (cs_n) begin
      next_st.miso_oe = 1'b0;
      next_st.miso    = 1'b0;
    end else if (sck_fall && cmd == CMD_RDSR &&
                 st.byte_cnt != 2'h0) begin
      next_st.miso_oe = 1'b1;
      next_st.miso    = rd_byte[3'h7 - st.bit_cnt];
    end

    // commands other than status read are ignored while erasing
    if (cs_rise && !erase_busy) begin
      if (misaligned) begin
        if (cmd == CMD_CHIP_ERASE) begin
          next_st.write_latch_flag = 1'b0;
        end
      end else if (aligned) begin
        unique case (cmd)
          CMD_WREN: begin
            next_st.write_latch_flag = 1'b1;
          end
          CMD_WRDI: begin
            next_st.write_latch_flag = 1'b0;
          end
          CMD_CHIP_ERASE: begin
            // latch clears on a skipped or a started erase alike
            if (st.write_latch_flag) begin
              next_st.write_latch_flag = 1'b0;
            end
          end
          CMD_WRSR: begin
            if (st.write_latch_flag && st.byte_cnt >= 2'h2 && !hw_locked) begin
              next_st.bp0   = st.wr_byte[SR_BP0];
              next_st.nv_we = 1'b1;
              if (wp_n) begin
                next_st.protect_lock_bit = st.wr_byte[SR_BPL];
              end else begin
                next_st.protect_lock_bit = st.protect_lock_bit | st.wr_byte[SR_BPL];
              end
              next_st.write_latch_flag = 1'b0;
            end
          end
          CMD_RDSR, CMD_OTHER: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= GUARD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign miso_out                     = st.miso;
  assign miso_oe_out                  = st.miso_oe;
  assign bp0_nv_out                   = st.bp0;
  assign bp0_nv_we_out                = st.nv_we;
  assign array_erase_out              = erase_busy;
  assign write_latch_flag_out         = st.write_latch_flag;
  assign busy_out                     = erase_busy;
  assign array_protect_bit_out        = st.bp0;
  assign protect_lock_bit_out         = st.protect_lock_bit;
  assign erase_program_error_flag_out = erase_err;
  assign hw_locked_out                = hw_locked;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  wel_gate_a: assert property (erase_start |-> st.write_latch_flag)
    else $error("erase started without write latch");
  opcode_set_a: assert property (erase_start |->
      (st.opcode == OP_CE_A || st.opcode == OP_CE_B ||
       st.opcode == OP_CE_C))
    else $error("erase started by a wrong opcode");
  start_release_a: assert property (erase_start |-> cs_rise && aligned)
    else $error("erase started away from release");
  busy_shown_a: assert property (erase_start |=> busy_out [*8])
    else $error("busy not shown during erase");
  wel_cleared_a: assert property (erase_start |=> !st.write_latch_flag)
    else $error("latch still set after erase start");
  misalign_clear_a: assert property (cs_rise && misaligned &&
      !erase_busy && cmd == CMD_CHIP_ERASE |=> !st.write_latch_flag && !busy_out)
    else $error("misaligned erase not refused");
  protect_skip_a: assert property (cs_rise && aligned && st.bp0 &&
      cmd == CMD_CHIP_ERASE |-> !erase_start ##1 !st.write_latch_flag)
    else $error("protected array erased");
  error_flag_a: assert property (erase_done && $past(erase_fail_in)
      |-> erase_program_error_flag_out)
    else $error("erase failure not reported");
  wren_set_a: assert property (cs_rise && aligned && !erase_busy &&
      cmd == CMD_WREN |=> write_latch_flag_out)
    else $error("write enable did not set latch");
  abort_keep_a: assert property (cs_rise && st.byte_cnt == 2'h0
      |=> $stable(st.write_latch_flag))
    else $error("partial opcode changed latch");
  wrdi_clear_a: assert property (cs_rise && aligned && !erase_busy &&
      cmd == CMD_WRDI |=> !write_latch_flag_out)
    else $error("write disable did not clear latch");
  lock_freeze_a: assert property (hw_locked && st.loaded
      |=> $stable(st.bp0) && $stable(st.protect_lock_bit))
    else $error("locked protection bits changed");
  wrsr_refuse_a: assert property (cs_rise && aligned && !erase_busy &&
      cmd == CMD_WRSR && !st.write_latch_flag |=> $stable(st.bp0) && $stable(st.protect_lock_bit))
    else $error("status write taken without latch");
  pin_no_touch_a: assert property (!cs_rise && st.loaded
      |=> $stable(st.bp0))
    else $error("protect bit changed outside a command");

  erase_run_c: cover property (erase_start ##1 busy_out);
  wren_seen_c: cover property (cs_rise && aligned && cmd == CMD_WREN);
  status_wr_c: cover property (bp0_nv_we_out);
  status_rd_c: cover property (miso_oe_out && busy_out);
  misalign_c: cover property (cs_rise && misaligned);

endmodule

// ==== hw/pin_sync3.sv ====
// three-stage synchroniser with agreement filter for the pin inputs
`timescale 1ns/1ps
module pin_sync3
  import flash_guard_pkg::*;
(
  // clock and reset
  input  wire logic                clk_in,
  input  wire logic                srst_in,
  // raw pins and filtered levels
  input  wire logic [SYNC_W-1:0]   pins_in,
  output logic      [SYNC_W-1:0]   level_out
);
  import flash_guard_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] level;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a lane changes only once stages two and three agree
    next_st.level = (~(st.s2 ^ st.s3) & st.s2) |
                    ((st.s2 ^ st.s3) & st.level);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= {SYNC_RESET, SYNC_RESET, SYNC_RESET, SYNC_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.level;

endmodule

// ==== sim/flash_write_guard_tb_top.sv ====
// self-checking bench of the flash write guard
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module flash_write_guard_tb_top;
  import flash_guard_pkg::*;
  // long enough that a status read fits inside one erase
  localparam int unsigned ERASE_N = 400;
  logic        clk_in, srst_in, sck, cs_n, mosi, miso, miso_oe;
  logic        wp_n, bp0_nv_in, bp0_nv, bp0_we, erase_fail, erase;
  logic        wlf, busy, bp0, lock, erase_program_error_flag, hw_locked;
  logic [15:0] rx;
  logic [7:0]  ops [3];
  int          fails, cmp_count, we_cnt, oe_cnt, oe_base;

  flash_write_guard #(.ERASE_CYCLES(ERASE_N)) DUT (
    .clk_in                       (clk_in),
    .srst_in                      (srst_in),
    .sck_in                       (sck),
    .cs_n_in                      (cs_n),
    .mosi_in                      (mosi),
    .miso_out                     (miso),
    .miso_oe_out                  (miso_oe),
    .wp_n_in                      (wp_n),
    .bp0_nv_in                    (bp0_nv_in),
    .bp0_nv_out                   (bp0_nv),
    .bp0_nv_we_out                (bp0_we),
    .erase_fail_in                (erase_fail),
    .array_erase_out              (erase),
    .write_latch_flag_out         (wlf),
    .busy_out                     (busy),
    .array_protect_bit_out        (bp0),
    .protect_lock_bit_out         (lock),
    .erase_program_error_flag_out (erase_program_error_flag),
    .hw_locked_out                (hw_locked)
  );

  spi_host_model host (
    .clk_in   (clk_in),
    .sck_out  (sck),
    .cs_n_out (cs_n),
    .mosi_out (mosi),
    .miso_in  (miso)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (bp0_we === 1'b1)
      we_cnt++;
    if (miso_oe === 1'b1)
      oe_cnt++;
  end

  task automatic cmd(input logic [23:0] d, input int n);
    host.xfer(d, n, rx);
  endtask

  task automatic wren();
    cmd({16'h0000, OP_WREN}, 8);
  endtask

  task automatic wrsr(input logic [7:0] v);
    wren();
    cmd({8'h00, OP_WRSR, v}, 16);
  endtask

  task automatic wp_level(input logic v);
    wp_n <= v;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 1000 && busy !== 1'b0; i++)
      @(posedge clk_in);
    `CHK(busy, 1'b0)
  endtask

  task automatic conclude();
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    srst_in    = 1'b1;
    wp_n       = 1'b1;
    bp0_nv_in  = 1'b0;
    erase_fail = 1'b0;
    ops        = '{OP_CE_A, OP_CE_B, OP_CE_C};
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK({wlf, busy, bp0, lock, erase_program_error_flag}, 5'h00)
    cmd({19'h00000, OP_WREN[7:3]}, 5);
    `CHK(wlf, 1'b0)
    wren();
    `CHK(wlf, 1'b1)
    cmd({15'h0000, OP_WRDI, 1'b1}, 9);
    `CHK(wlf, 1'b1)
    cmd({8'h00, OP_WRDI, 8'ha5}, 16);
    `CHK(wlf, 1'b0)
    cmd({16'h0000, OP_CE_C}, 8);
    `CHK({busy, erase}, 2'b00)
    `CHK(oe_cnt, 0)
    // every erase opcode, trailing byte, a failing array on the second
    for (int k = 0; k < 3; k++) begin
      wren();
      erase_fail <= (k == 1);
      cmd({8'h00, ops[k], 8'hff}, 16);
      `CHK({busy, erase, wlf}, 3'b110)
      oe_base = oe_cnt;
      cmd({OP_RDSR, 16'h0000}, 24);
      `CHK({miso_oe, oe_cnt != oe_base}, 2'b01)
      `CHK({rx[8+SR_BUSY], rx[SR2_BUSY], rx[8+SR_WEL]}, 3'b110)
      wait_idle();
      `CHK(erase_program_error_flag, (k == 1))
      erase_fail <= 1'b0;
    end
    wren();
    cmd({15'h0000, OP_CE_B, 1'b0}, 9);
    `CHK({busy, wlf}, 2'b00)
    wren();
    cmd({20'h00000, OP_CE_A[7:4]}, 4);
    `CHK({busy, wlf}, 2'b01)
    wrsr(8'h04);
    `CHK({bp0, bp0_nv}, 2'b11)
    wren();
    cmd({16'h0000, OP_CE_A}, 8);
    `CHK({busy, erase, wlf}, 3'b000)
    wrsr(8'h84);
    `CHK({lock, hw_locked, bp0}, 3'b101)
    wrsr(8'h80);
    `CHK({lock, bp0}, 2'b10)
    wp_level(1'b0);
    `CHK({hw_locked, bp0}, 2'b10)
    wrsr(8'h04);
    `CHK({lock, bp0}, 2'b10)
    wp_level(1'b1);
    wrsr(8'h00);
    `CHK({lock, hw_locked}, 2'b00)
    cmd({8'h00, OP_WRSR, 8'h80}, 16);
    `CHK(lock, 1'b0)
    wp_level(1'b0);
    wrsr(8'h80);
    `CHK(lock, 1'b1)
    wrsr(8'h00);
    `CHK(lock, 1'b1)
    `CHK(we_cnt, 5)
    // a second reset reloads the protect bit from its store
    bp0_nv_in <= 1'b1;
    srst_in   <= 1'b1;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    `CHK({bp0, lock, wlf}, 3'b100)
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    conclude();
  end
endmodule

// ==== sim/spi_host_model.sv ====
// serial bus host model issuing flash commands in mode 0
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input  wire logic clk_in,
  // bus pins
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // serial clock rests low between frames, as mode 0 wants
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // msb first, 8 clk per bit; miso is taken at the next fall because the
  // device answers about five clocks after the pin edge
  task automatic xfer(input logic [23:0] data, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    mosi_out <= data[nbits-1];
    for (int i = nbits - 1; i >= 0; i--) begin
      repeat (4) @(posedge clk_in);
      sck_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      if (nbits - i > 8)
        rx = {rx[14:0], miso_in};
      sck_out <= 1'b0;
      if (i > 0)
        mosi_out <= data[i-1];
    end
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // released data line must not keep showing the last bit
    mosi_out <= ~mosi_out;
    repeat (12) @(posedge clk_in);
  endtask
endmodule
